// >>> rtl/ushp_consts.vh
`ifndef USHP_CONSTS_VH
`define USHP_CONSTS_VH

// status byte bit positions
`define USHP_ST_TX_FREE     0
`define USHP_ST_RX_AVAIL    1
`define USHP_ST_TX_EMPTY    2
`define USHP_ST_DSR         7

// command byte bit positions
`define USHP_CMD_TX_EN      0
`define USHP_CMD_DTR        1
`define USHP_CMD_RTS        5
`define USHP_CMD_SW_RESET   6

// mode byte fields
`define USHP_MODE_FACT_LSB  0
`define USHP_MODE_LEN_LSB   2
`define USHP_MODE_ONE_SYNC  7

// clock factor field codes
`define USHP_FACT_SYNC      2'h0
`define USHP_FACT_X1        2'h1
`define USHP_FACT_X16       2'h2
`define USHP_FACT_X64       2'h3

// bit clock edges per bit, minus one
`define USHP_DIV_X1         6'h00
`define USHP_DIV_X16        6'h0f
`define USHP_DIV_X64        6'h3f

// shortest character, in data bits
`define USHP_MIN_CHAR_BITS  4'h5

// reset values
`define USHP_RESET_MODE     8'h00
`define USHP_RESET_CMD      8'h00
`define USHP_RESET_SYNC     8'h00

`endif

// >>> rtl/ushp_sync2.v
`timescale 1ns/1ps

// two-flop synchroniser for pins from outside the clock domain
module ushp_sync2 #(
    parameter         W    = 1,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    // system
    input  wire         clock,
    input  wire         reset,
    // pins
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clock) begin
        if (reset) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule // ushp_sync2

// >>> rtl/ushp_tx_shifter.v
`timescale 1ns/1ps

// parallel to serial shifter, lsb first, one bit per bit_tick
module ushp_tx_shifter #(
    parameter FW = 10,
    parameter CW = 4
) (
    // system
    input  wire          clock,
    input  wire          reset,
    input  wire          flush,
    // timing
    input  wire          bit_tick,
    // frame load
    input  wire          load,
    input  wire [FW-1:0] frame,
    input  wire [CW-1:0] frame_len,
    // state and line
    output wire          busy,
    output reg           serial_out
);

    reg [FW-1:0] sh_q;
    reg [CW-1:0] cnt_q;

    assign busy = (cnt_q != {CW{1'b0}});

    always @(posedge clock) begin
        if (reset || flush) begin
            sh_q       <= {FW{1'b0}};
            cnt_q      <= {CW{1'b0}};
            serial_out <= 1'b1;
        end else if (load && bit_tick) begin
            // load on the edge that ends the previous last bit
            serial_out <= frame[0];
            sh_q       <= {1'b0, frame[FW-1:1]};
            cnt_q      <= frame_len - {{(CW-1){1'b0}}, 1'b1};
        end else if (load) begin
            sh_q  <= frame;
            cnt_q <= frame_len;
        end else if (bit_tick && busy) begin
            serial_out <= sh_q[0];
            sh_q       <= {1'b0, sh_q[FW-1:1]};
            cnt_q      <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end else if (bit_tick) begin
            serial_out <= 1'b1;
        end
    end

endmodule // ushp_tx_shifter

// >>> rtl/ushp_host_port.v
`timescale 1ns/1ps
`include "ushp_consts.vh"

// What this block does
// - chip select high: bus undriven, read and write strobes ignored.
// - select low, c_d 0: read returns rx buffer, write loads tx buffer.
// - select low, c_d 1: read gives status, write is a control byte.
// - reset high holds the block idle; its release enters standby.
// - standby ends only when a mode byte is written.
// - status bit 7 shows data-set-ready.
// - terminal-ready pin is the inverse of command bit 1.
// - request-to-send pin is the inverse of command bit 5.
// - transmit only with clear-to-send low and transmit enable set.
// - clear-to-send lost mid-send: finish written data, then hold line high.
// - holding-free pin gated by empty buffer, enable and clear-to-send.
// - status bit 0 shows holding buffer empty, ungated.
// - holding-free clears at the falling edge of a data write.
// - data write over a full holding buffer overwrites unsent data.
// - shifter done: holding moves to shifter, holding-free set.
// - all-empty set when shifter done and holding buffer empty.
// - async: all-empty idles line high; data write clears it.
// - sync: all-empty starts sending the stored sync characters.
// - sync: all-empty clears only after sync characters and new data.
// - bits shift out on the falling edge of the transmit bit clock.
// - control path writes land in the mode, sync character and command bytes.
// - status readable at all times except in standby.
module ushp_host_port #(
    parameter DW = 8,
    parameter FW = 10
) (
    // system
    input  wire          clock,
    input  wire          reset,
    // host bus
    input  wire          cs_n,
    input  wire          rd_n,
    input  wire          wr_n,
    input  wire          c_d,
    input  wire [DW-1:0] data_in,
    output reg  [DW-1:0] data_out,
    output reg           data_oe,
    // receiver side
    input  wire [DW-1:0] rx_char,
    input  wire          rx_char_strobe,
    output reg           rx_char_available,
    // modem
    input  wire          dsr_n,
    input  wire          cts_n,
    output reg           dtr_n,
    output reg           rts_n,
    // transmitter
    input  wire          tx_bit_clock,
    output wire          serial_out_line,
    output reg           tx_holding_free,
    output reg           tx_all_empty,
    output reg           standby_mode
);

    localparam [3:0] ST_STANDBY = 4'h1;
    localparam [3:0] ST_SYNC1   = 4'h2;
    localparam [3:0] ST_SYNC2   = 4'h4;
    localparam [3:0] ST_CMD     = 4'h8;

    localparam SW = DW + 7;

    // synchronised pins
    wire [SW-1:0] pins_s;
    wire          cs_s;
    wire          rd_s;
    wire          wr_s;
    wire          cd_s;
    wire          dsr_s;
    wire          cts_s;
    wire          txc_s;
    wire [DW-1:0] data_s;

    ushp_sync2 #(
        .W    (SW),
        .INIT ({SW{1'b1}})
    ) u_sync (
        .clock (clock),
        .reset (reset),
        .din   ({data_in, tx_bit_clock, cts_n, dsr_n, c_d, wr_n, rd_n,
                 cs_n}),
        .dout  (pins_s)
    );

    assign {data_s, txc_s, cts_s, dsr_s, cd_s, wr_s, rd_s, cs_s} = pins_s;

    // registers
    reg [3:0]    ctl_q;
    reg [DW-1:0] mode_q;
    reg [DW-1:0] cmd_q;
    reg [DW-1:0] sync0_q;
    reg [DW-1:0] sync1_q;
    reg [DW-1:0] hold_q;
    reg [DW-1:0] rx_buf_q;
    reg [DW-1:0] wdata_q;
    reg          hold_full_q;
    reg          wr_prev_q;
    reg          rd_prev_q;
    reg          txc_prev_q;
    reg          wr_pend_q;
    reg          wr_cd_q;
    reg          run_q;
    reg          sync_idx_q;
    reg [5:0]    div_q;

    wire stby       = ctl_q[0];
    wire sync_mode  = (mode_q[1:0] == `USHP_FACT_SYNC);
    wire two_sync   = ~mode_q[`USHP_MODE_ONE_SYNC];
    wire tx_en      = cmd_q[`USHP_CMD_TX_EN];
    wire tx_gate    = tx_en & ~cts_s;

    // strobe falls only while selected; a write rise ends any pending write
    wire wr_fall    = ~cs_s & ~wr_s & wr_prev_q;
    wire wr_rise    = wr_s & ~wr_prev_q & wr_pend_q;
    wire rd_act     = ~cs_s & ~rd_s;
    wire rd_fall    = rd_act & rd_prev_q;
    wire data_wfall = wr_fall & ~cd_s & ~stby;
    wire data_wdone = wr_rise & ~wr_cd_q;
    wire ctl_wdone  = wr_rise & wr_cd_q;
    wire sw_reset   = ctl_wdone & ctl_q[3] & wdata_q[`USHP_CMD_SW_RESET];

    // transmit bit clock: count falling edges per bit
    wire       txc_fall = ~txc_s & txc_prev_q;
    reg  [5:0] div_top;

    always @* begin
        case (mode_q[1:0])
            `USHP_FACT_X16: div_top = `USHP_DIV_X16;
            `USHP_FACT_X64: div_top = `USHP_DIV_X64;
            default:        div_top = `USHP_DIV_X1;
        endcase
    end

    wire bit_tick = txc_fall & (div_q == div_top);

    // frame builder: async adds start and stop, sync sends bare bits
    wire [3:0]    nbits  = `USHP_MIN_CHAR_BITS +
                           {2'h0, mode_q[`USHP_MODE_LEN_LSB+1:
                                         `USHP_MODE_LEN_LSB]};
    wire [FW-1:0] dmask  = ~({FW{1'b1}} << nbits);
    reg  [DW-1:0] char_sel;
    reg  [FW-1:0] frame;
    reg  [3:0]    frame_len;

    // transmit scheduling
    wire sh_busy;
    wire wr_hold    = wr_pend_q & ~wr_cd_q;
    wire load_data  = ~stby & ~sh_busy & hold_full_q & ~wr_hold &
                      (tx_gate | run_q) &
                      (~sync_mode | ~sync_idx_q);
    wire load_sync  = ~stby & sync_mode & ~sh_busy & ~load_data &
                      tx_gate & (sync_idx_q | tx_all_empty);
    wire load       = load_data | load_sync;

    always @* begin
        if (load_data) begin
            char_sel = hold_q;
        end else if (sync_idx_q) begin
            char_sel = sync1_q;
        end else begin
            char_sel = sync0_q;
        end
        if (sync_mode) begin
            frame     = {{(FW-DW){1'b0}}, char_sel} & dmask;
            frame_len = nbits;
        end else begin
            frame     = ((({{(FW-DW){1'b0}}, char_sel} & dmask)
                          << 1) | ~(dmask << 1)) & ~{{(FW-1){1'b0}}, 1'b1};
            frame_len = nbits + 4'h2;
        end
    end

    ushp_tx_shifter #(
        .FW (FW),
        .CW (4)
    ) u_shift (
        .clock      (clock),
        .reset      (reset),
        .flush      (stby),
        .bit_tick   (bit_tick),
        .load       (load),
        .frame      (frame),
        .frame_len  (frame_len),
        .busy       (sh_busy),
        .serial_out (serial_out_line)
    );

    // status byte
    wire [DW-1:0] status;
    assign status = {~dsr_s, 3'h0, 1'b0, tx_all_empty,
                     rx_char_available, ~hold_full_q};

    // edge history and write capture
    always @(posedge clock) begin
        if (reset) begin
            wr_prev_q  <= 1'b1;
            rd_prev_q  <= 1'b1;
            txc_prev_q <= 1'b1;
            wr_pend_q  <= 1'b0;
            wr_cd_q    <= 1'b0;
            wdata_q    <= {DW{1'b0}};
        end else begin
            wr_prev_q  <= wr_s;
            rd_prev_q  <= ~rd_act;
            txc_prev_q <= txc_s;
            if (wr_fall) begin
                wr_pend_q <= 1'b1;
                wr_cd_q   <= cd_s;
            end else if (wr_rise) begin
                wr_pend_q <= 1'b0;
            end
            // bus data is held until the strobe rises
            if (~wr_s) begin
                wdata_q <= data_s;
            end
        end
    end

    // control path: mode, sync characters, commands
    always @(posedge clock) begin
        if (reset || sw_reset) begin
            ctl_q   <= ST_STANDBY;
            mode_q  <= `USHP_RESET_MODE;
            cmd_q   <= `USHP_RESET_CMD;
            sync0_q <= `USHP_RESET_SYNC;
            sync1_q <= `USHP_RESET_SYNC;
        end else if (ctl_wdone) begin
            case (ctl_q)
                ST_STANDBY: begin
                    mode_q <= wdata_q;
                    if (wdata_q[1:0] == `USHP_FACT_SYNC) begin
                        ctl_q <= ST_SYNC1;
                    end else begin
                        ctl_q <= ST_CMD;
                    end
                end
                ST_SYNC1: begin
                    sync0_q <= wdata_q;
                    if (two_sync) begin
                        ctl_q <= ST_SYNC2;
                    end else begin
                        ctl_q <= ST_CMD;
                    end
                end
                ST_SYNC2: begin
                    sync1_q <= wdata_q;
                    ctl_q   <= ST_CMD;
                end
                ST_CMD: begin
                    cmd_q <= wdata_q;
                end
                default: begin
                    ctl_q <= ST_STANDBY;
                end
            endcase
        end
    end

    // holding buffer and transmit sequencing
    always @(posedge clock) begin
        if (reset || stby) begin
            hold_q      <= {DW{1'b0}};
            hold_full_q <= 1'b0;
            run_q       <= 1'b0;
            sync_idx_q  <= 1'b0;
            div_q       <= 6'h00;
            tx_all_empty <= 1'b1;
        end else begin
            // the write's falling edge beats a same-cycle transfer
            if (data_wfall) begin
                hold_full_q <= 1'b1;
            end else if (load_data) begin
                hold_full_q <= 1'b0;
            end
            if (data_wdone) begin
                hold_q <= wdata_q;
            end
            if (load_data) begin
                run_q <= 1'b1;
            end else if (~sh_busy & ~hold_full_q) begin
                run_q <= 1'b0;
            end
            if (load_sync) begin
                sync_idx_q <= two_sync & ~sync_idx_q;
            end
            if (txc_fall) begin
                if (div_q == div_top) begin
                    div_q <= 6'h00;
                end else begin
                    div_q <= div_q + 6'h01;
                end
            end
            if (~sync_mode & data_wfall) begin
                tx_all_empty <= 1'b0;
            end else if (load_data) begin
                tx_all_empty <= 1'b0;
            end else if (~sh_busy & ~hold_full_q & ~load) begin
                tx_all_empty <= 1'b1;
            end
        end
    end

    // receive buffer: a new character wins over a same-cycle read
    always @(posedge clock) begin
        if (reset || stby) begin
            rx_buf_q          <= {DW{1'b0}};
            rx_char_available <= 1'b0;
        end else if (rx_char_strobe) begin
            rx_buf_q          <= rx_char;
            rx_char_available <= 1'b1;
        end else if (rd_fall & ~cd_s) begin
            rx_char_available <= 1'b0;
        end
    end

    // bus drive and pin outputs
    always @(posedge clock) begin
        if (reset) begin
            data_out        <= {DW{1'b0}};
            data_oe         <= 1'b0;
            dtr_n           <= 1'b1;
            rts_n           <= 1'b1;
            tx_holding_free <= 1'b0;
            standby_mode    <= 1'b1;
        end else begin
            if (cd_s) begin
                data_out <= status;
            end else begin
                data_out <= rx_buf_q;
            end
            // status is withheld in standby
            data_oe         <= rd_act & ~(cd_s & stby);
            dtr_n           <= ~cmd_q[`USHP_CMD_DTR];
            rts_n           <= ~cmd_q[`USHP_CMD_RTS];
            tx_holding_free <= ~stby & ~hold_full_q & ~data_wfall &
                               tx_gate;
            standby_mode    <= stby;
        end
    end

endmodule // ushp_host_port

// >>> verif/ushp_chk_assertions.sv
`timescale 1ns/1ps
module ushp_chk (
    // system
    input wire       clock,
    input wire       reset,
    // host bus
    input wire       cs_n,
    input wire       rd_n,
    input wire       wr_n,
    input wire       c_d,
    input wire [7:0] data_out,
    input wire       data_oe,
    // receive and modem
    input wire       rx_char_strobe,
    input wire       rx_char_available,
    input wire       dsr_n,
    input wire       cts_n,
    input wire       dtr_n,
    input wire       rts_n,
    // transmitter
    input wire       serial_out_line,
    input wire       tx_holding_free,
    input wire       tx_all_empty,
    input wire       standby_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // pins pass two sync flops and one register: four samples cover it
    property p_cs_quiet;
        cs_n [*4] |-> !data_oe;
    endproperty
    a_cs_quiet: assert property (p_cs_quiet)
        else $error("bus driven while deselected");

    property p_data_rd;
        (!cs_n && !rd_n && !c_d) [*4] |-> data_oe;
    endproperty
    a_data_rd: assert property (p_data_rd)
        else $error("data read not answered");

    property p_stat_rd;
        (!cs_n && !rd_n && c_d && !standby_mode) [*4] |-> data_oe;
    endproperty
    a_stat_rd: assert property (p_stat_rd)
        else $error("status read not answered");

    property p_stby_rd;
        (standby_mode && c_d) [*4] |-> !data_oe;
    endproperty
    a_stby_rd: assert property (p_stby_rd)
        else $error("status driven in standby");

    property p_dsr;
        (!cs_n && !rd_n && c_d && !standby_mode && !dsr_n) [*4]
            |-> data_out[7];
    endproperty
    a_dsr: assert property (p_dsr)
        else $error("status bit 7 misses set-ready");

    property p_rst;
        $fell(reset) |-> standby_mode && dtr_n && rts_n && tx_all_empty
            && serial_out_line && !tx_holding_free;
    endproperty
    a_rst: assert property (p_rst)
        else $error("bad state after reset release");

    property p_rx;
        rx_char_strobe && !standby_mode |=> rx_char_available;
    endproperty
    a_rx: assert property (p_rx)
        else $error("received char not flagged");

    property p_cts_gate;
        cts_n [*4] |-> !tx_holding_free;
    endproperty
    a_cts_gate: assert property (p_cts_gate)
        else $error("holding free while send blocked");

    property p_free_drop;
        (!cs_n && !wr_n && !c_d && !standby_mode) [*4] |-> !tx_holding_free;
    endproperty
    a_free_drop: assert property (p_free_drop)
        else $error("holding free during data write");

    property p_stby_line;
        standby_mode [*3] |-> serial_out_line && tx_all_empty;
    endproperty
    a_stby_line: assert property (p_stby_line)
        else $error("line not idle in standby");
endmodule // ushp_chk

// >>> verif/ushp_host_model.sv
`timescale 1ns/1ps
module ushp_host_model (
    // system
    input  wire       clock,
    // bus strobes
    output logic      cs_n,
    output logic      rd_n,
    output logic      wr_n,
    output logic      c_d,
    // data bus
    output wire [7:0] data_in,
    input  wire [7:0] data_out,
    input  wire       data_oe
);
    logic [7:0] drv_q  = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic       drv_on = 1'b0;
    // floating bus toggles so a stale value never reads as valid
    wire  [7:0] bus = data_oe ? data_out : drv_on ? drv_q : ~last_q;

    assign data_in = bus;
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        c_d  = 1'b0;
    end
    always @(posedge clock) begin
        last_q <= bus;
    end

    // strobe four clocks, select held one past it, gap six clocks
    task automatic access(input logic sel_n, cd, wr, input logic [7:0] d,
                          output logic [7:0] q, output logic oe);
        @(posedge clock);
        cs_n   <= sel_n;
        c_d    <= cd;
        drv_q  <= d;
        drv_on <= wr;
        wr_n   <= !wr;
        rd_n   <= wr;
        repeat (4) @(posedge clock);
        q = bus;
        oe = data_oe;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        @(posedge clock);
        cs_n   <= 1'b1;
        drv_on <= 1'b0;
        repeat (6) @(posedge clock);
    endtask
endmodule // ushp_host_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       tx_bit_clock = 1'b1;
    logic       rx_char_strobe = 1'b0;
    logic [7:0] rx_char = 8'h00;
    logic       dsr_n = 1'b1;
    logic       cts_n = 1'b1;
    logic [7:0] q, c, sh;
    logic       oe;
    logic [7:0] exp_q[$];
    int         bad_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    wire        cs_n, rd_n, wr_n, c_d, data_oe, rx_char_available;
    wire        dtr_n, rts_n, serial_out_line, tx_holding_free;
    wire        tx_all_empty, standby_mode;
    wire  [7:0] data_in, data_out;

    ushp_host_port i_ushp_host_port (.clock, .reset, .cs_n, .rd_n, .wr_n,
        .c_d, .data_in, .data_out, .data_oe, .rx_char, .rx_char_strobe,
        .rx_char_available, .dsr_n, .cts_n, .dtr_n, .rts_n, .tx_bit_clock,
        .serial_out_line, .tx_holding_free, .tx_all_empty, .standby_mode);
    ushp_host_model i_ushp_host_model (.clock, .cs_n, .rd_n, .wr_n, .c_d,
        .data_in, .data_out, .data_oe);

    initial begin
        forever #20 clock = ~clock;
    end
    // 8 system clocks per bit clock: only legal for x16 or x64
    initial begin
        #7;
        forever #160 tx_bit_clock = ~tx_bit_clock;
    end

    task automatic chk(input string n, input logic [7:0] e, s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic s, cd, w, input logic [7:0] d);
        i_ushp_host_model.access(s, cd, w, d, q, oe);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic drain;
        for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clock);
        chk("tx_left", 8'h00, 8'(exp_q.size()));
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // x16, 8 data bits: 128 clocks a bit, sampled mid bit
    always begin
        @(negedge serial_out_line);
        wt(64);
        chk("start_bit", 8'h00, 8'(serial_out_line));
        for (int i = 0; i < 8; i++) begin
            wt(128);
            sh[i] = serial_out_line;
        end
        wt(128);
        chk("stop_bit", 8'h01, 8'(serial_out_line));
        chk("tx_char", exp_q.size() > 0 ? exp_q[0] : 8'hxx, sh);
        if (exp_q.size() > 0) void'(exp_q.pop_front());
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        void'($urandom(75));
        wt(20);
        reset <= 1'b0;
        wt(1);
        chk("reset_pins", 8'h3e, {2'b00, standby_mode, dtr_n, rts_n,
            tx_all_empty, serial_out_line, tx_holding_free});
        acc(0, 1, 0, 0);
        chk("stat_in_standby", 8'h00, 8'(oe));
        acc(0, 0, 1, 8'h5a);
        chk("data_in_standby", 8'h01, 8'(tx_all_empty));
        acc(1, 1, 1, 8'h0e);
        acc(1, 0, 0, 0);
        chk("deselected", 8'h02, {6'h00, standby_mode, oe});
        acc(0, 1, 1, 8'h0e);
        chk("mode_taken", 8'h00, 8'(standby_mode));
        for (int i = 0; i < 4; i++) begin
            c = 8'($urandom) & 8'h22;
            dsr_n <= i[0];
            acc(0, 1, 1, c);
            chk("dtr_n", 8'(!c[1]), 8'(dtr_n));
            chk("rts_n", 8'(!c[5]), 8'(rts_n));
            acc(0, 1, 0, 0);
            chk("status", {!i[0], 7'h05}, q);
        end
        rx_char <= 8'($urandom);
        rx_char_strobe <= 1'b1;
        wt(1);
        rx_char_strobe <= 1'b0;
        c = rx_char;
        wt(1);
        chk("rx_flag_set", 8'h01, 8'(rx_char_available));
        acc(0, 1, 0, 0);
        chk("status_rx", 8'h07, q);
        acc(0, 0, 0, 0);
        chk("rx_data", c, q);
        chk("rx_flag_clear", 8'h00, 8'(rx_char_available));
        cts_n <= 1'b0;
        acc(0, 1, 1, 8'h01);
        chk("free_gated_on", 8'h01, 8'(tx_holding_free));
        cts_n <= 1'b1;
        wt(6);
        chk("free_gated_off", 8'h00, 8'(tx_holding_free));
        acc(0, 1, 0, 0);
        chk("status_ungated", 8'h05, q);
        cts_n <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            c = 8'($urandom);
            if (i != 1) exp_q.push_back(c);
            acc(0, 0, 1, c);
        end
        chk("free_after_write", 8'h00, 8'(tx_holding_free));
        cts_n <= 1'b1;
        drain();
        wt(300);
        chk("idle_line", 8'h03, {6'h00, tx_all_empty,
            serial_out_line});
        c = 8'($urandom);
        exp_q.push_back(c);
        acc(0, 0, 1, c);
        wt(600);
        chk("held_by_cts", 8'h01, 8'(exp_q.size()));
        chk("empty_cleared", 8'h00, 8'(tx_all_empty));
        acc(0, 1, 0, 0);
        chk("status_held", 8'h00, q);
        cts_n <= 1'b0;
        drain();
        acc(0, 1, 1, 8'h40);
        chk("soft_reset", 8'h01, 8'(standby_mode));
        acc(0, 1, 1, 8'h0e);
        acc(0, 1, 1, 8'h02);
        chk("mode_then_cmd", 8'h00, {6'h00, standby_mode, dtr_n});
        c = 8'($urandom);
        acc(0, 0, 1, c);
        wt(300);
        acc(0, 1, 0, 0);
        chk("held_by_tx_enable_bit", 8'h00, q);
        conclude();
    end
endmodule // testbench

bind ushp_host_port ushp_chk i_ushp_chk (.clock, .reset, .cs_n, .rd_n,
    .wr_n, .c_d, .data_out, .data_oe, .rx_char_strobe, .rx_char_available,
    .dsr_n, .cts_n, .dtr_n, .rts_n, .serial_out_line, .tx_holding_free,
    .tx_all_empty, .standby_mode);
